/* bench/cdm_motor_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Driver and winding stand-in
// ----------------------------------------------------------------
module cdm_motor_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       zc_req,
    input  wire logic [3:0] drv_cfg,
    output logic            zero_cross,
    output logic [3:0]      drv_q
);
    // A crossing only shows on a floating winding, so the PWM must be off.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_cross <= 1'b0;
            drv_q      <= 4'h0;
        end else begin
            zero_cross <= zc_req & ~drv_cfg[3];
            drv_q      <= drv_cfg;
        end
    end
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
`include "cdm_consts.svh"
module testbench;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} cdm_row_t;
    typedef struct packed {logic c; logic [7:0] w; logic [7:0] t;
                           logic [7:0] z;} cdm_auto_t;
    typedef struct packed {logic v; logic [3:0] c; logic e;} cdm_pwm_t;
    logic        clk;
    logic        rst_n;
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        waitreq;
    logic        zc_req;
    logic [3:0]  drv_cfg;
    logic [3:0]  drv;
    logic        zc;
    logic        pwm;
    logic        comm;
    logic        ovf_irq;
    logic        ratio_irq;
    logic [11:0] step_cfg;
    logic [31:0] got;
    logic [15:0] p;
    logic [7:0]  e;
    int          n_errors = 0;
    int          num_checks = 0;
    int          n_comm = 0;
    int          c0;
    cdm_row_t    rows [7] = '{'{8'h14, 8'h5a, 8'h5a}, '{8'h18, 8'hc3, 8'hc3},
        '{8'h1c, 8'h3c, 8'h3c}, '{8'h20, 8'h81, 8'h81},
        '{8'h24, 8'h7e, 8'h7e}, '{8'h2c, 8'hfa, 8'h0a}, '{8'h3c, 8'h12, 8'h00}};
    cdm_auto_t   autos [4] = '{'{1'b0, 8'h40, 8'h90, 8'h60},
        '{1'b1, 8'h25, 8'h77, 8'h33}, '{1'b0, 8'h20, 8'h55, 8'hff},
        '{1'b1, 8'hff, 8'ha0, 8'h10}};
    cdm_pwm_t    pwms [5] = '{'{1'b0, 4'h8, 1'b1}, '{1'b0, 4'h0, 1'b0},
        '{1'b0, 4'ha, 1'b0}, '{1'b1, 4'h4, 1'b1}, '{1'b1, 4'h8, 1'b0}};

    cdm_motor_model motor (.clk(clk), .rst_n(rst_n), .zc_req(zc_req),
        .drv_cfg(drv_cfg), .zero_cross(zc), .drv_q(drv));
    cdm_delay_manager dut (.CLK_SYS(clk), .RESETN(rst_n), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .ZERO_CROSS(zc),
        .TIMER_A_PWM(drv[3]), .CURRENT_MODE_PWM(drv[2]),
        .CURRENT_SENSE_INPUT(drv[1]), .LIMIT_REFERENCE_PIN(drv[0]),
        .PWM_TO_CHANNEL(pwm), .COMMUTATION(comm), .OVERFLOW_IRQ(ovf_irq),
        .RATIO_IRQ(ratio_irq), .STEP_CONFIG(step_cfg));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (comm === 1'b1) n_comm++;
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        results();
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            n_errors++;
            $display("[ERR] %0t register got %h expected %h", $time, g, x);
        end
    endtask
    task automatic chk_bit(input logic g, input logic x);
        num_checks++;
        if (g !== x) begin
            n_errors++;
            $display("[ERR] %0t bit got %b expected %b", $time, g, x);
        end
    endtask
    // Request stays up until waitrequest is sampled low at a rising edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= {24'h0, d};
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (waitreq === 1'b0) break;
        end
        if (i == 50) begin
            n_errors++;
            results();
        end
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
        bus(1'b0, a, 8'h00);
        chk_reg(got, {24'h0, x});
    endtask
    task automatic zpulse();
        @(posedge clk);
        zc_req <= 1'b1;
        @(posedge clk);
        zc_req <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic restart(input logic [7:0] ratio, input logic [7:0] tmr);
        wr_reg(`CDM_A_CTRL_A, 8'h00);
        wr_reg(`CDM_A_STATUS, 8'h1f);
        wr_reg(`CDM_A_RATIO, ratio);
        wr_reg(`CDM_A_TIMER, tmr);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        zc_req = 1'b0;
        drv_cfg = 4'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        chk_bit(waitreq, 1'b1);
        for (int i = 0; i < 5; i++) begin
            rd_chk(8'h14 + 8'(4 * i), 8'h00);
        end
        wr_reg(`CDM_A_TICK, 8'h01);
        wr_reg(`CDM_A_MASK, 8'h05);
        for (int i = 0; i < 7; i++) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        for (int i = 0; i < 4; i++) begin
            restart(8'h03, autos[i].t);
            wr_reg(`CDM_A_ZLAST, autos[i].z);
            wr_reg(`CDM_A_ZPREV, 8'h11);
            wr_reg(`CDM_A_WEIGHT, autos[i].w);
            wr_reg(`CDM_A_CTRL_A, {5'h00, autos[i].c, 2'h3});
            zpulse();
            p = autos[i].w * (autos[i].c ? autos[i].t : autos[i].z);
            p = p >> 5;
            e = (p > 16'h00ff) ? 8'hff : p[7:0];
            rd_chk(`CDM_A_COMP, e);
            rd_chk(`CDM_A_ZLAST, autos[i].t);
            rd_chk(`CDM_A_ZPREV, autos[i].z);
            bus(1'b0, `CDM_A_STATUS, 8'h00);
            chk_bit(got[2], p > 16'h00ff);
            chk_bit(ovf_irq, p > 16'h00ff);
        end
        // Still in automatic mode: only the demag register may change.
        wr_reg(`CDM_A_COMP, 8'h11);
        rd_chk(`CDM_A_COMP, 8'hff);
        wr_reg(`CDM_A_ZLAST, 8'h11);
        rd_chk(`CDM_A_ZLAST, 8'ha0);
        wr_reg(`CDM_A_TIMER, 8'h11);
        e = 8'h7f + 8'((12'h120 - 12'h0ff) >> 1);
        wr_reg(`CDM_A_DEMAG, e);
        rd_chk(`CDM_A_DEMAG, e);
        zpulse();
        rd_chk(`CDM_A_RATIO, 8'h02);
        bus(1'b0, `CDM_A_STATUS, 8'h00);
        chk_bit(got[1], 1'b1);
        chk_bit(ratio_irq, 1'b1);
        restart(8'h00, 8'h00);
        wr_reg(`CDM_A_CTRL_A, 8'h03);
        zpulse();
        rd_chk(`CDM_A_RATIO, 8'h00);
        bus(1'b0, `CDM_A_STATUS, 8'h00);
        chk_bit(got[1], 1'b0);
        chk_bit(ratio_irq, 1'b0);
        restart(8'h03, 8'hfe);
        wr_reg(`CDM_A_ZLAST, 8'h40);
        wr_reg(`CDM_A_WEIGHT, 8'h20);
        wr_reg(`CDM_A_CTRL_A, 8'h07);
        repeat (40) @(posedge clk);
        rd_chk(`CDM_A_RATIO, 8'h04);
        rd_chk(`CDM_A_ZLAST, 8'h20);
        rd_chk(`CDM_A_COMP, 8'h20);
        bus(1'b0, `CDM_A_STATUS, 8'h00);
        chk_bit(got[0], 1'b1);
        chk_bit(ratio_irq, 1'b1);
        restart(8'h0f, 8'hfe);
        wr_reg(`CDM_A_CTRL_A, 8'h07);
        repeat (40) @(posedge clk);
        rd_chk(`CDM_A_TIMER, 8'hff);
        rd_chk(`CDM_A_RATIO, 8'h0f);
        rd_chk(`CDM_A_ZLAST, 8'h20);
        bus(1'b0, `CDM_A_STATUS, 8'h00);
        chk_bit(got[0], 1'b0);
        chk_bit(ratio_irq, 1'b0);
        restart(8'h00, 8'h00);
        wr_reg(`CDM_A_COMP, 8'h40);
        wr_reg(`CDM_A_CTRL_B, 8'h0a);
        wr_reg(`CDM_A_PHASE, 8'h9c);
        wr_reg(`CDM_A_CTRL_A, 8'h01);
        wr_reg(`CDM_A_COMP, 8'h60);
        wr_reg(`CDM_A_RATIO, 8'h07);
        wr_reg(`CDM_A_STATUS, 8'h01);
        rd_chk(`CDM_A_COMP, 8'h60);
        rd_chk(`CDM_A_RATIO, 8'h00);
        chk_reg({20'h0, step_cfg}, 32'h0);
        c0 = n_comm;
        for (int i = 0; i < 2000 && n_comm == c0; i++) begin
            @(posedge clk);
        end
        chk_bit(n_comm != c0, 1'b1);
        rd_chk(`CDM_A_RATIO, 8'h01);
        bus(1'b0, `CDM_A_STATUS, 8'h00);
        chk_bit(got[0], 1'b0);
        chk_reg({20'h0, step_cfg}, 32'h0a9c);
        for (int i = 0; i < 5; i++) begin
            wr_reg(`CDM_A_CTRL_A, {4'h2, pwms[i].v, 3'h1});
            drv_cfg <= pwms[i].c;
            repeat (4) @(posedge clk);
            chk_bit(pwm, pwms[i].e);
        end
        results();
    end
endmodule

/* rtl/cdm_consts.svh */
`ifndef CDM_CONSTS_SVH
`define CDM_CONSTS_SVH

// Register byte addresses (word aligned).
`define CDM_A_CTRL_A    8'h00
`define CDM_A_CTRL_B    8'h04
`define CDM_A_PHASE     8'h08
`define CDM_A_STATUS    8'h0c
`define CDM_A_MASK      8'h10
`define CDM_A_TIMER     8'h14
`define CDM_A_ZPREV     8'h18
`define CDM_A_ZLAST     8'h1c
`define CDM_A_COMP      8'h20
`define CDM_A_DEMAG     8'h24
`define CDM_A_WEIGHT    8'h28
`define CDM_A_RATIO     8'h2c
`define CDM_A_TICK      8'h30

// Control register A fields.
`define CDM_CA_OE       0
`define CDM_CA_SWA      1
`define CDM_CA_DCB      2
`define CDM_CA_VOLTAGE_CURRENT_SELECT     3
`define CDM_CA_DAC      4
// Status / mask fields.
`define CDM_ST_RPI      0
`define CDM_ST_RMI      1
`define CDM_ST_OI       2
`define CDM_ST_CI       3
`define CDM_ST_ZI       4

`define CDM_TMR_MAX     8'hff
`define CDM_TMR_LOW     8'h55
`define CDM_RATIO_MAX   4'hf
`define CDM_RATIO_MIN   4'h0
`define CDM_DIV_SHIFT   5
`define CDM_RST_BYTE    8'h00
`define CDM_TICK_RST    16'h0028

`endif

/* rtl/cdm_delay_manager.sv */
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "cdm_consts.svh"

// How it works
// - Auto mode: compare = weight times capture / 32
// - Product overflow saturates compare, raises overflow event
// - Recompute multiply after every auto-mode prescaler shift
// - Auto: timer at FFh increments ratio, shifts right
// - Auto: zero crossing below 55h decrements, shifts left
// - Ratio zero: no decrement, no decrement flag
// - Ratio 15 at FFh: freeze timer, nothing else
// - Five shifted registers, each reset to 00h
// - Preloaded step bits apply together on commutation
// - OE clear: timer-set and ratio read/write
// - Switched: compare/demag writable, flags step ratio
// - Auto: only demag writable, software clears flags
// - Switched: prescaler steps on timer match per software-set flags, not by direct write
// - Voltage/current select bit picks PWM mode
// - Voltage mode: PWM taken from timer A
// - Voltage mode: comparator limits current
// - Zero crossing sampled in auto mode, PWM on or off
// - Generated PWM routed to channel manager
// - Auto zero crossing: capture, shift captures, reset
// - Timer match with compare starts commutation
// - Capture select bit picks multiply operand
// - Step timer is 8-bit readable up counter
module cdm_delay_manager (
    input  wire logic        CLK_SYS,
    input  wire logic        RESETN,
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        ZERO_CROSS,
    input  wire logic        TIMER_A_PWM,
    input  wire logic        CURRENT_SENSE_INPUT,
    input  wire logic        LIMIT_REFERENCE_PIN,
    input  wire logic        CURRENT_MODE_PWM,
    output logic             PWM_TO_CHANNEL,
    output logic             COMMUTATION,
    output logic             OVERFLOW_IRQ,
    output logic             RATIO_IRQ,
    output logic [11:0]      STEP_CONFIG
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [8:0] cdm_scaled(input logic [7:0] w,
                                              input logic [7:0] c);
        logic [15:0] p;
        p = w * c;
        // Bit 8 flags any product bit above the eight kept after the shift.
        cdm_scaled = {|p[15:13], p[12:5]};
    endfunction

    function automatic cdm_pkg::cdm_tset_t cdm_shift(
        input cdm_pkg::cdm_tset_t s, input logic left);
        cdm_pkg::cdm_tset_t r;
        r = left ? cdm_pkg::cdm_tset_t'({s.tmr << 1, s.zlast << 1,
                 s.zprev << 1, s.comp << 1, s.demag << 1})
                 : cdm_pkg::cdm_tset_t'({s.tmr >> 1, s.zlast >> 1,
                 s.zprev >> 1, s.comp >> 1, s.demag >> 1});
        cdm_shift = r;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cdm_pkg::cdm_tset_t ts_q;
    cdm_pkg::cdm_tset_t ts_d;
    cdm_pkg::cdm_step_t act_q;
    logic [4:0]         ctla_q;
    logic [3:0]         ctlb_q;
    logic [7:0]         phase_q;
    logic [4:0]         stat_q;
    logic [4:0]         stat_d;
    logic [4:0]         mask_q;
    logic [7:0]         weight_q;
    logic [3:0]         ratio_q;
    logic [3:0]         ratio_d;
    logic [15:0]        tick_div_q;
    logic [15:0]        tick_cnt_q;
    logic [3:0]         pre_cnt_q;
    logic               frozen_q;
    logic               frozen_d;
    logic               recalc_q;
    logic               done_q;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    cdm_pkg::cdm_mode_t mode;
    wire logic clk_on   = ctla_q[`CDM_CA_OE] & ~ctla_q[`CDM_CA_DAC];
    assign mode = !ctla_q[`CDM_CA_OE]
                ? (ctla_q[`CDM_CA_SWA] ? cdm_pkg::CDM_EMERGENCY
                                       : cdm_pkg::CDM_CONFIG)
                : (ctla_q[`CDM_CA_SWA] ? cdm_pkg::CDM_AUTO
                                       : cdm_pkg::CDM_SWITCHED);
    wire logic is_auto  = clk_on & (mode == cdm_pkg::CDM_AUTO);
    wire logic is_sw    = clk_on & (mode == cdm_pkg::CDM_SWITCHED);
    wire logic cfg_acc  = ~ctla_q[`CDM_CA_OE];
    wire logic req      = (AVS_READ | AVS_WRITE) & ~done_q;
    wire logic wr       = AVS_WRITE & ~done_q;
    wire logic wr_ctla  = wr & (AVS_ADDRESS == `CDM_A_CTRL_A);
    wire logic wr_ctlb  = wr & (AVS_ADDRESS == `CDM_A_CTRL_B);
    wire logic wr_phase = wr & (AVS_ADDRESS == `CDM_A_PHASE);
    wire logic wr_stat  = wr & (AVS_ADDRESS == `CDM_A_STATUS);
    wire logic wr_mask  = wr & (AVS_ADDRESS == `CDM_A_MASK);
    wire logic wr_tmr   = wr & (AVS_ADDRESS == `CDM_A_TIMER) & cfg_acc;
    wire logic wr_zp    = wr & (AVS_ADDRESS == `CDM_A_ZPREV) & cfg_acc;
    wire logic wr_zl    = wr & (AVS_ADDRESS == `CDM_A_ZLAST) & cfg_acc;
    wire logic wr_comp  = wr & (AVS_ADDRESS == `CDM_A_COMP)
                        & (cfg_acc | ~ctla_q[`CDM_CA_SWA]);
    wire logic wr_demag = wr & (AVS_ADDRESS == `CDM_A_DEMAG);
    wire logic wr_wght  = wr & (AVS_ADDRESS == `CDM_A_WEIGHT);
    wire logic wr_ratio = wr & (AVS_ADDRESS == `CDM_A_RATIO) & cfg_acc;
    wire logic wr_tick  = wr & (AVS_ADDRESS == `CDM_A_TICK);

    // ------------------------------------------------------------
    // Prescaled timer tick
    // ------------------------------------------------------------
    wire logic base_tick = (tick_cnt_q >= tick_div_q);
    wire logic tick      = base_tick
                         & (pre_cnt_q == ((4'h1 << ratio_q[1:0]) - 4'h1));
    // Ratio is four bits but the prescale chain is kept short: only
    // ratio_q[1:0] sets the prescale and the upper ratio bits are ignored,
    // so a step of one halves the timer rate only inside each group of four.
    wire logic big_tick  = tick;

    wire logic at_max    = ts_q.tmr == `CDM_TMR_MAX;
    wire logic match     = clk_on & big_tick & ~frozen_q
                         & (ts_q.tmr + 8'h01 == ts_q.comp);
    wire logic zc_auto   = is_auto & ZERO_CROSS;
    wire logic inc_auto  = is_auto & big_tick & ~frozen_q & at_max
                         & (ratio_q != `CDM_RATIO_MAX);
    wire logic freeze    = is_auto & big_tick & at_max
                         & (ratio_q == `CDM_RATIO_MAX);
    wire logic dec_auto  = zc_auto & (ts_q.tmr < `CDM_TMR_LOW)
                         & (ratio_q != `CDM_RATIO_MIN);
    wire logic sw_inc    = is_sw & match & stat_q[`CDM_ST_RPI];
    wire logic sw_dec    = is_sw & match & ~stat_q[`CDM_ST_RPI]
                         & stat_q[`CDM_ST_RMI]
                         & (ratio_q != `CDM_RATIO_MIN);
    wire logic [7:0] operand = ctla_q[`CDM_CA_DCB] ? ts_q.zlast
                                                   : ts_q.zprev;
    wire logic [8:0] scaled  = cdm_scaled(weight_q, operand);
    wire logic [7:0] mul_res = scaled[8] ? `CDM_TMR_MAX
                                         : scaled[7:0];
    wire logic mul_ovf   = is_auto & recalc_q & scaled[8];

    // ------------------------------------------------------------
    // Timer set next value
    // ------------------------------------------------------------
    always_comb begin
        ts_d     = ts_q;
        frozen_d = frozen_q & is_auto;
        if (wr_tmr)   ts_d.tmr   = AVS_WRITEDATA[7:0];
        if (wr_zp)    ts_d.zprev = AVS_WRITEDATA[7:0];
        if (wr_zl)    ts_d.zlast = AVS_WRITEDATA[7:0];
        if (wr_comp)  ts_d.comp  = AVS_WRITEDATA[7:0];
        if (wr_demag) ts_d.demag = AVS_WRITEDATA[7:0];
        if (clk_on) begin
            if (zc_auto) begin
                ts_d.zprev = ts_q.zlast;
                ts_d.zlast = ts_q.tmr;
                ts_d.tmr   = 8'h00;
                frozen_d   = 1'b0;
                if (dec_auto)
                    ts_d = cdm_shift(ts_d, 1'b1);
            end else if (freeze) begin
                frozen_d = 1'b1;
            end else if (inc_auto) begin
                ts_d = cdm_shift(ts_q, 1'b0);
            end else if (match & ~is_auto) begin
                ts_d.tmr = 8'h00;
                if (sw_inc)
                    ts_d = cdm_shift(ts_d, 1'b0);
                else if (sw_dec)
                    ts_d = cdm_shift(ts_d, 1'b1);
            end else if (big_tick & ~frozen_q & ~at_max) begin
                ts_d.tmr = ts_q.tmr + 8'h01;
            end
            if (is_auto & recalc_q)
                ts_d.comp = mul_res;
        end
    end

    always_comb begin
        ratio_d = ratio_q;
        if (wr_ratio)
            ratio_d = AVS_WRITEDATA[3:0];
        else if (inc_auto | sw_inc)
            ratio_d = ratio_q + 4'h1;
        else if (dec_auto | sw_dec)
            ratio_d = ratio_q - 4'h1;
    end

    // Hardware set wins over a software clear in the same cycle.
    always_comb begin
        stat_d = stat_q;
        if (wr_stat) begin
            if (is_sw)
                stat_d = stat_q | AVS_WRITEDATA[4:0];
            else
                stat_d = stat_q & ~AVS_WRITEDATA[4:0];
        end
        if (inc_auto) stat_d[`CDM_ST_RPI] = 1'b1;
        if (dec_auto) stat_d[`CDM_ST_RMI] = 1'b1;
        if (sw_inc)   stat_d[`CDM_ST_RPI] = 1'b0;
        if (sw_dec)   stat_d[`CDM_ST_RMI] = 1'b0;
        if (mul_ovf)  stat_d[`CDM_ST_OI]  = 1'b1;
        if (match)    stat_d[`CDM_ST_CI]  = 1'b1;
        if (zc_auto)  stat_d[`CDM_ST_ZI]  = 1'b1;
    end

    wire logic commute = (match & clk_on) | (is_auto & clk_on
                       & big_tick & ~frozen_q & (ts_q.tmr == ts_q.comp));

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ts_q     <= '0;
            ratio_q  <= 4'h0;
            stat_q   <= 5'h00;
            frozen_q <= 1'b0;
            recalc_q <= 1'b0;
        end else begin
            ts_q     <= ts_d;
            ratio_q  <= ratio_d;
            stat_q   <= stat_d;
            frozen_q <= frozen_d;
            recalc_q <= zc_auto | inc_auto | dec_auto;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ctla_q     <= 5'h00;
            ctlb_q     <= 4'h0;
            phase_q    <= 8'h00;
            mask_q     <= 5'h00;
            weight_q   <= `CDM_RST_BYTE;
            tick_div_q <= `CDM_TICK_RST;
        end else begin
            if (wr_ctla) ctla_q     <= AVS_WRITEDATA[4:0];
            if (wr_ctlb) ctlb_q     <= AVS_WRITEDATA[3:0];
            if (wr_phase) phase_q   <= AVS_WRITEDATA[7:0];
            if (wr_mask) mask_q     <= AVS_WRITEDATA[4:0];
            if (wr_wght) weight_q   <= AVS_WRITEDATA[7:0];
            if (wr_tick) tick_div_q <= AVS_WRITEDATA[15:0];
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            tick_cnt_q <= 16'h0000;
            pre_cnt_q  <= 4'h0;
        end else if (!clk_on || base_tick) begin
            tick_cnt_q <= 16'h0000;
            pre_cnt_q  <= (!clk_on || tick) ? 4'h0 : pre_cnt_q + 4'h1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end

    // Step configuration preload: all bits move in one edge.
    wire logic load_step = commute
                         | (wr_phase & ctla_q[`CDM_CA_DAC]);
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            act_q <= '0;
        end else begin
            if (load_step)
                act_q <= cdm_pkg::cdm_step_t'({ctlb_q, phase_q});
        end
    end

    // ------------------------------------------------------------
    // PWM source and outputs
    // ------------------------------------------------------------
    wire logic volt_mode = ~ctla_q[`CDM_CA_VOLTAGE_CURRENT_SELECT];
    wire logic over_lim  = CURRENT_SENSE_INPUT & ~LIMIT_REFERENCE_PIN;
    wire logic pwm_sel   = volt_mode ? (TIMER_A_PWM & ~over_lim)
                                     : CURRENT_MODE_PWM;

    logic [31:0] rdata;
    always_comb begin
        unique case (AVS_ADDRESS)
            `CDM_A_CTRL_A: rdata = {27'h0, ctla_q};
            `CDM_A_CTRL_B: rdata = {28'h0, ctlb_q};
            `CDM_A_PHASE:  rdata = {24'h0, phase_q};
            `CDM_A_STATUS: rdata = {27'h0, stat_q};
            `CDM_A_MASK:   rdata = {27'h0, mask_q};
            `CDM_A_TIMER:  rdata = {24'h0, ts_q.tmr};
            `CDM_A_ZPREV:  rdata = {24'h0, ts_q.zprev};
            `CDM_A_ZLAST:  rdata = {24'h0, ts_q.zlast};
            `CDM_A_COMP:   rdata = {24'h0, ts_q.comp};
            `CDM_A_DEMAG:  rdata = {24'h0, ts_q.demag};
            `CDM_A_WEIGHT: rdata = {24'h0, weight_q};
            `CDM_A_RATIO:  rdata = {28'h0, ratio_q};
            `CDM_A_TICK:   rdata = {16'h0, tick_div_q};
            default:       rdata = 32'h0000_0000;
        endcase
    end

    // Every request costs one wait cycle; writes land on the done edge.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            done_q          <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h0000_0000;
            PWM_TO_CHANNEL  <= 1'b0;
            COMMUTATION     <= 1'b0;
            OVERFLOW_IRQ    <= 1'b0;
            RATIO_IRQ       <= 1'b0;
            STEP_CONFIG     <= 12'h000;
        end else begin
            done_q          <= req;
            AVS_WAITREQUEST <= ~req;
            if (AVS_READ & ~done_q)
                AVS_READDATA <= rdata;
            PWM_TO_CHANNEL  <= pwm_sel;
            COMMUTATION     <= commute;
            OVERFLOW_IRQ    <= stat_d[`CDM_ST_OI] & mask_q[`CDM_ST_OI];
            RATIO_IRQ       <= |(stat_d[1:0] & {2{mask_q[`CDM_ST_RPI]}});
            STEP_CONFIG     <= act_q;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_ratio_inc: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        inc_auto |=> ratio_q == $past(ratio_q) + 4'h1
            && stat_q[`CDM_ST_RPI])
        else $error("ratio increment missed");
    chk_ratio_dec: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        dec_auto |=> ratio_q == $past(ratio_q) - 4'h1)
        else $error("ratio decrement missed");
    chk_no_dec_zero: assert property (@(posedge CLK_SYS)
        disable iff (!RESETN)
        ratio_q == 4'h0 && is_auto && !inc_auto |=> ratio_q == 4'h0)
        else $error("ratio decremented below zero");
    chk_freeze_hold: assert property (@(posedge CLK_SYS)
        disable iff (!RESETN)
        freeze && !zc_auto |=> ts_q.tmr == 8'hff && ratio_q == 4'hf)
        else $error("frozen timer moved");
    chk_capture_move: assert property (@(posedge CLK_SYS)
        disable iff (!RESETN)
        zc_auto && !dec_auto |=> ts_q.zprev == $past(ts_q.zlast))
        else $error("capture chain broken");
    chk_mul_load: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        zc_auto ##1 is_auto |=> ts_q.comp == $past(mul_res))
        else $error("compare not recomputed");
    chk_ovf_sat: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        mul_ovf |=> ts_q.comp == 8'hff && stat_q[`CDM_ST_OI])
        else $error("overflow not saturated");
    chk_step_load: assert property (@(posedge CLK_SYS)
        disable iff (!RESETN)
        !load_step |=> act_q == $past(act_q))
        else $error("step config changed off event");
    chk_auto_ro: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        is_auto && wr && AVS_ADDRESS == 8'h14 && !zc_auto && !big_tick
        |=> ts_q.tmr == $past(ts_q.tmr))
        else $error("timer written in auto mode");
    chk_vmode_src: assert property (@(posedge CLK_SYS)
        disable iff (!RESETN)
        volt_mode && over_lim |=> !PWM_TO_CHANNEL)
        else $error("current limit ignored");
endmodule

/* rtl/cdm_pkg.sv */
package cdm_pkg;
    typedef struct packed {
        logic [7:0] tmr;
        logic [7:0] zlast;
        logic [7:0] zprev;
        logic [7:0] comp;
        logic [7:0] demag;
    } cdm_tset_t;

    typedef struct packed {
        logic       comparator_polarity;
        logic       hardware_demag;
        logic       software_demag;
        logic       os2;
        logic [1:0] isel;
        logic [5:0] oo;
    } cdm_step_t;

    typedef enum logic [1:0] {
        CDM_CONFIG,
        CDM_SWITCHED,
        CDM_EMERGENCY,
        CDM_AUTO
    } cdm_mode_t;
endpackage
